// *** hw/odacr_pkg.sv ***
// register map, field positions and codes of the display and acquisition control bank
// assumes a 32-bit AXI4-Lite master; every register is one aligned word, data in bits 7:0
package odacr_pkg;
    // ==================================================================
    // register byte offsets
    localparam int ODACR_ADDR_W = 8;
    localparam logic [7:0] OFS_FRAME = 8'h00;
    localparam logic [7:0] OFS_SYNC = 8'h04;
    localparam logic [7:0] OFS_FEAT = 8'h10;
    localparam logic [7:0] OFS_MIXA = 8'h14;
    localparam logic [7:0] OFS_MIXB = 8'h18;
    localparam logic [7:0] OFS_CURBOX = 8'h1C;
    localparam logic [7:0] OFS_ACQ = 8'h20;
    localparam logic [7:0] OFS_ROW = 8'h24;
    localparam logic [7:0] OFS_COL = 8'h28;
    localparam logic [7:0] OFS_DATA = 8'h2C;
    localparam logic [7:0] OFS_SIG = 8'h30;
    localparam logic [7:0] OFS_CLR = 8'h34;
    localparam logic [7:0] OFS_BLK = 8'h3C;
    localparam logic [7:0] OFS_FORCE = 8'h44;
    // ==================================================================
    // field positions
    localparam int FRM_AUTO = 0;
    localparam int FRM_DIS = 1;
    localparam int SYN_FIELD = 0;
    localparam int SYN_H = 1;
    localparam int SYN_V = 2;
    localparam int FEAT_ALT = 7, FEAT_QUAD = 6, FEAT_EAST = 5, FEAT_DHDIS = 4;
    localparam int FEAT_BMESH = 3, FEAT_CMESH = 2, FEAT_BLKVID = 1, FEAT_SHADOW = 0;
    localparam int MIX_BG_OUT = 7, MIX_BG_IN = 6, MIX_CUT_OUT = 5, MIX_CUT_IN = 4;
    localparam int MIX_TXT_OUT = 3, MIX_TXT_IN = 2, MIX_PIC_OUT = 1, MIX_PIC_IN = 0;
    localparam int CB_CURSOR = 4, CB_DBL = 3, CB_BOX24 = 2, CB_BOX1 = 1, CB_BOX0 = 0;
    localparam int ACQ_FLICK = 5, ACQ_SPAN = 4, ACQ_PKT = 3, ACQ_WIDE_DONE = 2, ACQ_WIDE_EN = 1, ACQ_INSEL = 0;
    localparam int ROW_FREEZE = 7;
    localparam int ROW_CLEAR = 6;
    localparam int SIG_525 = 6;
    localparam int SIG_LOCK = 0;
    localparam int CLR_BUSY = 1;
    localparam int CLR_D525 = 0;
    // ==================================================================
    // values and codes
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [1:0] FORCE_AUTO = 2'h0;
    localparam logic [1:0] FORCE_525 = 2'h1;
    localparam logic [1:0] FORCE_625 = 2'h2;
    localparam logic [1:0] FORCE_625_STD525 = 2'h3;
    localparam logic [4:0] FIRST_ROW = 5'h00;
    localparam logic [4:0] LAST_ROW = 5'h18;
    localparam int CLR_ADDR_W = 11;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {WR_IDLE, WR_EXEC, WR_RESP} odacr_wr_t;
endpackage : odacr_pkg

// *** hw/odacr_regs.sv ***
// control and status bank of the display generator and the video acquisition unit
// assumes AXI4-Lite on REF_CLK; acquisition and display inputs come from logic on REF_CLK
//
// Contract
// - auto frame bit set: frame output goes off while video is shown
// - frame disable bit set: frame output held low
// - field polarity bit selects vsync in second line half on even field
// - h and v polarity bits select negative-going sync reference edge
// - alternate bank bit adds 32 alternate character locations
// - quad width enable and global double height bits
// - eastern select uses eastern set for codes A0H to FFH
// - double height decode disable bit suppresses double height attribute
// - black mesh and colour mesh bits act independently
// - transparent black bit shows video instead of black background
// - shadow enable bit draws black shadow around characters
// - two identical sets of inside and outside box mixing bits
// - cursor at pointer row and column; freeze locks it
// - box enables for row 0, rows 1 to 23, row 24
// - flicker stopper bit disables flicker stopping
// - Spanish disable bit stops special packet 26 treatment
// - packet 26 and widescreen done status bits set by hardware
// - widescreen acquired only when enabled; input select picks second input
// - indirect display memory access by row, column, block and data port
// - clear memory bit clears pointed block; page clearing status reads busy
// - 525 received, video lock, 525 display status and charset identifier
// - two-bit acquisition force field selects timing and standard
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module odacr_regs #(
    parameter int BLK_W = 1,
    parameter logic [4:0] CHARSET_IDENT = 5'h0A, // arbitrary value
    parameter logic [7:0] CLEAR_FILL = 8'h20
) (
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic [odacr_pkg::ODACR_ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [odacr_pkg::ODACR_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic VIDEO_SHOWN,
    input wire logic [4:0] DISP_ROW,
    input wire logic ENH_PKT_DONE,
    input wire logic WIDESCREEN_DONE,
    input wire logic SYNC_525_IN,
    input wire logic VIDEO_LOCK_IN,
    input wire logic DISPLAY_525_IN,
    output logic FRAME_OUT,
    output logic FIELD_POL,
    output logic HSYNC_NEG_EDGE,
    output logic VSYNC_NEG_EDGE,
    output logic [7:0] DISP_FEATURE,
    output logic DOUBLE_HEIGHT,
    output logic [7:0] MIX_SET_A,
    output logic [7:0] MIX_SET_B,
    output logic CURSOR_EN,
    output logic [4:0] CURSOR_ROW,
    output logic [5:0] CURSOR_COL,
    output logic BOX_ALLOWED,
    output logic FLICKER_STOP_DIS,
    output logic SPANISH_DIS,
    output logic WIDESCREEN_ACQ_EN,
    output logic VIDEO_INPUT_SELECT,
    output logic ACQ_AUTO,
    output logic ACQ_TIMING_525,
    output logic ACQ_STD_525,
    output logic PAGE_CLEARING
);
    import odacr_pkg::*;

    localparam int MEM_AW = BLK_W + CLR_ADDR_W;

    typedef struct packed {
        odacr_wr_t wst;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic bvalid;
        logic [1:0] bresp;
        logic [7:0] awaddr;
        logic [7:0] wdata;
        logic wlane;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic [1:0] frame;
        logic [2:0] sync;
        logic [7:0] feat;
        logic [7:0] mix_a;
        logic [7:0] mix_b;
        logic [4:0] curbox;
        logic flick;
        logic span;
        logic wss_en;
        logic in_sel;
        logic pkt_done;
        logic wss_done;
        logic freeze;
        logic [4:0] row;
        logic [5:0] col;
        logic [BLK_W-1:0] blk;
        logic [1:0] force_acq;
        logic clr_busy;
        logic [CLR_ADDR_W-1:0] clr_addr;
        logic [BLK_W-1:0] clr_blk;
        logic frame_out;
        logic box_ok;
        logic [4:0] cur_row;
        logic [5:0] cur_col;
        logic acq_auto;
        logic t525;
        logic s525;
    } odacr_state_t;

    odacr_state_t s;
    odacr_state_t next_s;
    logic [7:0] mem [0:(1<<MEM_AW)-1];
    logic [7:0] mem_rdata;
    logic mem_we;
    logic [MEM_AW-1:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [MEM_AW-1:0] rd_addr;

    // ==================================================================
    // display memory, one write port shared by clear engine and software
    assign rd_addr = {s.blk, s.row, s.col};

    always_ff @(posedge REF_CLK) begin
        if (mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
        mem_rdata <= mem[rd_addr];
    end

    // ==================================================================
    // next state
    always_comb begin
        logic [7:0] ra;
        logic [7:0] wa;
        logic [7:0] rd;
        logic [1:0] rr;
        ra = {S_AXI_ARADDR[7:2], 2'b00};
        wa = {s.awaddr[7:2], 2'b00};
        rd = 8'h00;
        rr = RESP_OKAY;
        next_s = s;
        mem_we = 1'b0;
        mem_waddr = {s.blk, s.row, s.col};
        mem_wdata = s.wdata;

        // clear engine walks one byte per cycle; power-on clear starts from reset
        if (s.clr_busy) begin
            mem_we = 1'b1;
            mem_waddr = {s.clr_blk, s.clr_addr};
            mem_wdata = CLEAR_FILL;
            next_s.clr_addr = s.clr_addr + {{(CLR_ADDR_W-1){1'b0}}, 1'b1};
            if (&s.clr_addr) next_s.clr_busy = 1'b0;
        end

        case (s.wst)
            WR_IDLE: begin
                if (S_AXI_AWVALID && s.awready) begin
                    next_s.awready = 1'b0;
                    next_s.aw_got = 1'b1;
                    next_s.awaddr = S_AXI_AWADDR;
                end else if (!s.aw_got) begin
                    next_s.awready = 1'b1;
                end
                if (S_AXI_WVALID && s.wready) begin
                    next_s.wready = 1'b0;
                    next_s.w_got = 1'b1;
                    next_s.wdata = S_AXI_WDATA[7:0];
                    next_s.wlane = S_AXI_WSTRB[0];
                end else if (!s.w_got) begin
                    next_s.wready = 1'b1;
                end
                if (s.aw_got && s.w_got) begin
                    next_s.wst = WR_EXEC;
                end
            end
            WR_EXEC: begin
                // a data port write waits for a running clear to finish
                if (!(wa == OFS_DATA && s.clr_busy)) begin
                    next_s.wst = WR_RESP;
                    next_s.bvalid = 1'b1;
                    next_s.bresp = RESP_OKAY;
                    next_s.aw_got = 1'b0;
                    next_s.w_got = 1'b0;
                    if (wa == OFS_FRAME) begin
                        if (s.wlane) next_s.frame = s.wdata[1:0];
                    end else if (wa == OFS_SYNC) begin
                        if (s.wlane) next_s.sync = s.wdata[2:0];
                    end else if (wa == OFS_FEAT) begin
                        if (s.wlane) next_s.feat = s.wdata;
                    end else if (wa == OFS_MIXA) begin
                        if (s.wlane) next_s.mix_a = s.wdata;
                    end else if (wa == OFS_MIXB) begin
                        if (s.wlane) next_s.mix_b = s.wdata;
                    end else if (wa == OFS_CURBOX) begin
                        if (s.wlane) next_s.curbox = s.wdata[4:0];
                    end else if (wa == OFS_ACQ) begin
                        // done bits are not writable
                        if (s.wlane) begin
                            next_s.flick = s.wdata[ACQ_FLICK];
                            next_s.span = s.wdata[ACQ_SPAN];
                            next_s.wss_en = s.wdata[ACQ_WIDE_EN];
                            next_s.in_sel = s.wdata[ACQ_INSEL];
                        end
                    end else if (wa == OFS_ROW) begin
                        if (s.wlane) begin
                            next_s.freeze = s.wdata[ROW_FREEZE];
                            next_s.row = s.wdata[4:0];
                            if (s.wdata[ROW_CLEAR]) begin
                                next_s.clr_busy = 1'b1;
                                next_s.clr_addr = '0;
                                next_s.clr_blk = s.blk;
                            end
                        end
                    end else if (wa == OFS_COL) begin
                        if (s.wlane) next_s.col = s.wdata[5:0];
                    end else if (wa == OFS_DATA) begin
                        mem_we = s.wlane;
                    end else if (wa == OFS_BLK) begin
                        if (s.wlane) next_s.blk = s.wdata[BLK_W-1:0];
                    end else if (wa == OFS_FORCE) begin
                        if (s.wlane) next_s.force_acq = s.wdata[1:0];
                    end else if (wa == OFS_SIG || wa == OFS_CLR) begin
                        next_s.bresp = RESP_OKAY;
                    end else begin
                        next_s.bresp = RESP_SLVERR;
                    end
                end
            end
            WR_RESP: begin
                if (S_AXI_BREADY) begin
                    next_s.bvalid = 1'b0;
                    next_s.wst = WR_IDLE;
                end
            end
            default: next_s.wst = WR_IDLE;
        endcase

        // ==================================================================
        // read channel, answered in the cycle after the address is taken
        if (S_AXI_ARVALID && s.arready) begin
            if (ra == OFS_FRAME) begin
                rd = {6'h00, s.frame};
            end else if (ra == OFS_SYNC) begin
                rd = {5'h00, s.sync};
            end else if (ra == OFS_FEAT) begin
                rd = s.feat;
            end else if (ra == OFS_MIXA) begin
                rd = s.mix_a;
            end else if (ra == OFS_MIXB) begin
                rd = s.mix_b;
            end else if (ra == OFS_CURBOX) begin
                rd = {3'h0, s.curbox};
            end else if (ra == OFS_ACQ) begin
                rd = {2'h0, s.flick, s.span, s.pkt_done, s.wss_done, s.wss_en, s.in_sel};
                // done flags clear on read
                next_s.pkt_done = 1'b0;
                next_s.wss_done = 1'b0;
            end else if (ra == OFS_ROW) begin
                rd = {s.freeze, 2'h0, s.row};
            end else if (ra == OFS_COL) begin
                rd = {2'h0, s.col};
            end else if (ra == OFS_DATA) begin
                rd = mem_rdata;
            end else if (ra == OFS_SIG) begin
                rd = {1'b0, SYNC_525_IN, CHARSET_IDENT, VIDEO_LOCK_IN};
            end else if (ra == OFS_CLR) begin
                rd = {6'h00, s.clr_busy, DISPLAY_525_IN};
            end else if (ra == OFS_BLK) begin
                rd = 8'(s.blk);
            end else if (ra == OFS_FORCE) begin
                rd = {6'h00, s.force_acq};
            end else begin
                rr = RESP_SLVERR;
            end
            next_s.arready = 1'b0;
            next_s.rvalid = 1'b1;
            next_s.rdata = rd;
            next_s.rresp = rr;
        end else if (s.rvalid && S_AXI_RREADY) begin
            next_s.rvalid = 1'b0;
            next_s.arready = 1'b1;
        end else if (!s.rvalid && !s.arready) begin
            next_s.arready = 1'b1;
        end

        // ==================================================================
        // hardware events win over a clear in the same cycle
        if (ENH_PKT_DONE) next_s.pkt_done = 1'b1;
        if (WIDESCREEN_DONE && s.wss_en) next_s.wss_done = 1'b1;

        // ==================================================================
        // decoded controls for display and acquisition
        next_s.frame_out = !s.frame[FRM_DIS] && !(s.frame[FRM_AUTO] && VIDEO_SHOWN);
        if (DISP_ROW == FIRST_ROW) next_s.box_ok = s.curbox[CB_BOX0];
        else if (DISP_ROW < LAST_ROW) next_s.box_ok = s.curbox[CB_BOX1];
        else if (DISP_ROW == LAST_ROW) next_s.box_ok = s.curbox[CB_BOX24];
        else next_s.box_ok = 1'b0;
        if (!s.freeze) begin
            next_s.cur_row = s.row;
            next_s.cur_col = s.col;
        end
        // code 11 keeps 625 timing but the 525 standard
        next_s.acq_auto = (s.force_acq == FORCE_AUTO);
        next_s.t525 = (s.force_acq == FORCE_525);
        next_s.s525 = (s.force_acq == FORCE_525) || (s.force_acq == FORCE_625_STD525);
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            s <= '0;
            s.clr_busy <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ==================================================================
    // outputs
    assign S_AXI_AWREADY = s.awready;
    assign S_AXI_WREADY = s.wready;
    assign S_AXI_BVALID = s.bvalid;
    assign S_AXI_BRESP = s.bresp;
    assign S_AXI_ARREADY = s.arready;
    assign S_AXI_RVALID = s.rvalid;
    assign S_AXI_RRESP = s.rresp;
    assign S_AXI_RDATA = {24'h000000, s.rdata};
    assign FRAME_OUT = s.frame_out;
    assign FIELD_POL = s.sync[SYN_FIELD];
    assign HSYNC_NEG_EDGE = s.sync[SYN_H];
    assign VSYNC_NEG_EDGE = s.sync[SYN_V];
    assign DISP_FEATURE = s.feat;
    assign DOUBLE_HEIGHT = s.curbox[CB_DBL];
    assign MIX_SET_A = s.mix_a;
    assign MIX_SET_B = s.mix_b;
    assign CURSOR_EN = s.curbox[CB_CURSOR];
    assign CURSOR_ROW = s.cur_row;
    assign CURSOR_COL = s.cur_col;
    assign BOX_ALLOWED = s.box_ok;
    assign FLICKER_STOP_DIS = s.flick;
    assign SPANISH_DIS = s.span;
    assign WIDESCREEN_ACQ_EN = s.wss_en;
    assign VIDEO_INPUT_SELECT = s.in_sel;
    assign ACQ_AUTO = s.acq_auto;
    assign ACQ_TIMING_525 = s.t525;
    assign ACQ_STD_525 = s.s525;
    assign PAGE_CLEARING = s.clr_busy;

    // ==================================================================
    // checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    frame_dis_a: assert property (s.frame[FRM_DIS] |=> !FRAME_OUT) else $error("frame not held low");
    frame_auto_a: assert property (s.frame[FRM_AUTO] && VIDEO_SHOWN |=> !FRAME_OUT)
        else $error("frame not switched off under video");
    box_rows_a: assert property (DISP_ROW == LAST_ROW |=> BOX_ALLOWED == $past(s.curbox[CB_BOX24]))
        else $error("row 24 box enable not applied");
    cursor_freeze_a: assert property (s.freeze |=> $stable(CURSOR_ROW) && $stable(CURSOR_COL))
        else $error("frozen cursor moved");
    pkt_done_a: assert property (ENH_PKT_DONE |=> s.pkt_done) else $error("packet done not set");
    wss_gate_a: assert property (!s.wss_en && !s.wss_done |=> !s.wss_done)
        else $error("widescreen done set while disabled");
    clear_run_a: assert property ($rose(s.clr_busy) |-> s.clr_busy [*8])
        else $error("page clear ended early");
    clear_end_a: assert property ($fell(s.clr_busy) |-> s.clr_addr == '0 && PAGE_CLEARING == 1'b0)
        else $error("page clear ended off the block end");
    force_mix_a: assert property (s.force_acq == FORCE_625_STD525 |=> !ACQ_TIMING_525 && ACQ_STD_525)
        else $error("force code 11 decoded wrong");
    status_ro_a: assert property ($fell(s.pkt_done) |-> $past(S_AXI_ARVALID && s.arready))
        else $error("status bit cleared without a read");
    bvalid_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write response dropped");

    clear_done_c: cover property ($fell(s.clr_busy));
    data_write_c: cover property (mem_we && !s.clr_busy);
    acq_read_c: cover property (S_AXI_RVALID && S_AXI_RREADY);
    frame_auto_c: cover property (s.frame[FRM_AUTO] && VIDEO_SHOWN);

endmodule : odacr_regs

// *** tb/odacr_video_model.sv ***
// far-side model: video source status and display timing for the bank
// assumes REF_CLK domain; bench steers it through CMD
`timescale 1ns/1ns
module odacr_video_model (
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic [10:0] CMD,
    output logic VIDEO_SHOWN,
    output logic [4:0] DISP_ROW,
    output logic ENH_PKT_DONE,
    output logic WIDESCREEN_DONE,
    output logic SYNC_525_IN,
    output logic VIDEO_LOCK_IN,
    output logic DISPLAY_525_IN
);
    logic [10:0] st;
    // done lines pulse one cycle, since the bench pulses CMD for one cycle
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) st <= 11'h000;
        else st <= CMD;
    end
    assign {VIDEO_SHOWN, DISP_ROW, ENH_PKT_DONE, WIDESCREEN_DONE, SYNC_525_IN, VIDEO_LOCK_IN, DISPLAY_525_IN} = st;
endmodule : odacr_video_model

// *** tb/osd_display_acq_control_regs_tb_top.sv ***
// self-checking bench of the display and acquisition control bank
// assumes the video model on the far side; AXI4-Lite driven from here
`timescale 1ns/1ns
module osd_display_acq_control_regs_tb_top;
    import odacr_pkg::*;
    localparam logic [4:0] IDENT = 5'h13; // arbitrary value
    localparam logic [7:0] FILL = 8'h5A;
    localparam logic [7:0] OFS[9] = '{OFS_FRAME, OFS_SYNC, OFS_FEAT, OFS_MIXA, OFS_MIXB, OFS_CURBOX, OFS_ACQ, OFS_COL,
        OFS_FORCE};
    localparam logic [7:0] MSK[9] = '{8'h03, 8'h07, 8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'h33, 8'h3F, 8'h03};
    localparam logic [7:0] OMK[9] = '{8'h02, 8'h07, 8'hFF, 8'hFF, 8'hFF, 8'h18, 8'h33, 8'h3F, 8'h03};
    localparam logic [7:0] FEXP[4] = '{8'h04, 8'h03, 8'h00, 8'h01};
    localparam logic [4:0] RW[5] = '{5'h00, 5'h01, 5'h17, 5'h18, 5'h19};
    logic REF_CLK = 1'b0, RST_B = 1'b0, S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
    logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00, got;
    logic [31:0] S_AXI_WDATA = 32'h00000000, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB = 4'hF;
    logic [10:0] CMD = 11'h000;
    logic [16:0] seed = 17'h17FD5;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, VIDEO_SHOWN, ENH_PKT_DONE;
    logic WIDESCREEN_DONE, SYNC_525_IN, VIDEO_LOCK_IN, DISPLAY_525_IN, FRAME_OUT, FIELD_POL, HSYNC_NEG_EDGE;
    logic VSYNC_NEG_EDGE, DOUBLE_HEIGHT, CURSOR_EN, BOX_ALLOWED, FLICKER_STOP_DIS, SPANISH_DIS, WIDESCREEN_ACQ_EN;
    logic VIDEO_INPUT_SELECT, ACQ_AUTO, ACQ_TIMING_525, ACQ_STD_525, PAGE_CLEARING;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic [4:0] DISP_ROW, CURSOR_ROW;
    logic [5:0] CURSOR_COL;
    logic [7:0] DISP_FEATURE, MIX_SET_A, MIX_SET_B;
    int bad_count = 0, checked = 0;
    // ==================================================================
    // design and far side
    odacr_regs #(.CHARSET_IDENT(IDENT), .CLEAR_FILL(FILL)) i_dut (.REF_CLK, .RST_B, .S_AXI_AWADDR, .S_AXI_AWVALID,
        .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
        .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
        .S_AXI_RREADY, .VIDEO_SHOWN, .DISP_ROW, .ENH_PKT_DONE, .WIDESCREEN_DONE, .SYNC_525_IN, .VIDEO_LOCK_IN,
        .DISPLAY_525_IN, .FRAME_OUT, .FIELD_POL, .HSYNC_NEG_EDGE, .VSYNC_NEG_EDGE, .DISP_FEATURE, .DOUBLE_HEIGHT,
        .MIX_SET_A, .MIX_SET_B, .CURSOR_EN, .CURSOR_ROW, .CURSOR_COL, .BOX_ALLOWED, .FLICKER_STOP_DIS, .SPANISH_DIS,
        .WIDESCREEN_ACQ_EN, .VIDEO_INPUT_SELECT, .ACQ_AUTO, .ACQ_TIMING_525, .ACQ_STD_525, .PAGE_CLEARING);
    odacr_video_model i_video (.REF_CLK, .RST_B, .CMD, .VIDEO_SHOWN, .DISP_ROW, .ENH_PKT_DONE, .WIDESCREEN_DONE,
        .SYNC_525_IN, .VIDEO_LOCK_IN, .DISPLAY_525_IN);
    always #20 REF_CLK = ~REF_CLK;
    // ==================================================================
    // helpers
    task automatic stop_test;
        $display("mismatches %0d checks %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    // every wait is bounded; one clear of 2048 cycles fits inside
    task automatic tick(inout int n);
        @(posedge REF_CLK);
        n++;
        if (n > 4000) begin
            bad_count++;
            $display("mismatch %0t wait ran out", $time);
            stop_test();
        end
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge REF_CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= {24'h000000, d};
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        do begin
            tick(n);
            if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
        end while (S_AXI_BVALID !== 1'b1);
        S_AXI_BREADY <= 1'b0;
        chk({6'h00, S_AXI_BRESP}, {6'h00, r});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [1:0] r, output logic [7:0] d);
        int n;
        n = 0;
        @(posedge REF_CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do begin
            tick(n);
            if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
        end while (S_AXI_RVALID !== 1'b1);
        S_AXI_RREADY <= 1'b0;
        d = S_AXI_RDATA[7:0];
        chk({6'h00, S_AXI_RRESP}, {6'h00, r});
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        rd(a, RESP_OKAY, got);
        chk(got, e);
    endtask : rc
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction : lfsr
    function automatic logic [7:0] box_exp(input logic [2:0] b, input logic [4:0] r);
        if (r == 5'h00) return {7'h00, b[0]};
        if (r <= 5'h17) return {7'h00, b[1]};
        return {7'h00, r == 5'h18 && b[2]};
    endfunction : box_exp
    function automatic logic [7:0] obs(input int i);
        case (i)
            0: return {6'h00, !FRAME_OUT, 1'b0};
            1: return {5'h00, VSYNC_NEG_EDGE, HSYNC_NEG_EDGE, FIELD_POL};
            2: return DISP_FEATURE;
            3: return MIX_SET_A;
            4: return MIX_SET_B;
            5: return {3'h0, CURSOR_EN, DOUBLE_HEIGHT, 3'h0};
            6: return {2'h0, FLICKER_STOP_DIS, SPANISH_DIS, 2'h0, WIDESCREEN_ACQ_EN, VIDEO_INPUT_SELECT};
            7: return {2'h0, CURSOR_COL};
            8: return {6'h00, !ACQ_AUTO && !ACQ_TIMING_525, ACQ_STD_525};
            default: return 8'h00;
        endcase
    endfunction : obs
    // ==================================================================
    // main sequence
    initial begin
        int n;
        repeat (10) @(posedge REF_CLK);
        RST_B <= 1'b1;
        rc(OFS_CLR, 8'h02);
        for (int k = 0; k < 18; k++) begin
            seed = lfsr(seed);
            wr(OFS[k % 9], seed[7:0], RESP_OKAY);
            rc(OFS[k % 9], seed[7:0] & MSK[k % 9]);
            chk(obs(k % 9), seed[7:0] & OMK[k % 9]);
        end
        for (int k = 0; k < 8; k++) begin
            CMD <= {k[2], 10'h000};
            wr(OFS_FRAME, {6'h00, k[1:0]}, RESP_OKAY);
            repeat (3) @(posedge REF_CLK);
            chk({7'h00, FRAME_OUT}, {7'h00, !k[1] && !(k[0] && k[2])});
        end
        for (int k = 0; k < 4; k++) begin
            wr(OFS_FORCE, k[7:0], RESP_OKAY);
            repeat (2) @(posedge REF_CLK);
            chk({5'h00, ACQ_AUTO, ACQ_TIMING_525, ACQ_STD_525}, FEXP[k]);
        end
        for (int k = 0; k < 10; k++) begin
            if (k % 5 == 0) wr(OFS_CURBOX, k < 5 ? 8'h05 : 8'h02, RESP_OKAY);
            CMD <= {1'b0, RW[k % 5], 5'h00};
            repeat (3) @(posedge REF_CLK);
            chk({7'h00, BOX_ALLOWED}, box_exp(k < 5 ? 3'h5 : 3'h2, RW[k % 5]));
        end
        wr(OFS_ACQ, 8'h0C, RESP_OKAY);
        CMD <= 11'h018;
        @(posedge REF_CLK);
        CMD <= 11'h007;
        rc(OFS_ACQ, 8'h08);
        rc(OFS_ACQ, 8'h00);
        wr(OFS_ACQ, 8'h02, RESP_OKAY);
        CMD <= 11'h00F;
        @(posedge REF_CLK);
        CMD <= 11'h007;
        rc(OFS_ACQ, 8'h06);
        rc(OFS_SIG, {2'h1, IDENT, 1'b1});
        wr(OFS_SIG, 8'h00, RESP_OKAY);
        rc(OFS_SIG, {2'h1, IDENT, 1'b1});
        wr(8'h08, 8'h55, RESP_SLVERR);
        rd(8'h08, RESP_SLVERR, got);
        wr(OFS_ROW, 8'h05, RESP_OKAY);
        wr(OFS_ROW, 8'h89, RESP_OKAY);
        repeat (2) @(posedge REF_CLK);
        chk({3'h0, CURSOR_ROW}, 8'h05);
        rc(OFS_ROW, 8'h89);
        n = 0;
        while (PAGE_CLEARING !== 1'b0) tick(n);
        rc(OFS_CLR, 8'h01);
        wr(OFS_BLK, 8'h00, RESP_OKAY);
        wr(OFS_ROW, 8'h03, RESP_OKAY);
        wr(OFS_COL, 8'h07, RESP_OKAY);
        rc(OFS_DATA, FILL);
        seed = lfsr(seed);
        wr(OFS_DATA, seed[7:0], RESP_OKAY);
        rc(OFS_DATA, seed[7:0]);
        wr(OFS_ROW, 8'h43, RESP_OKAY);
        @(posedge REF_CLK);
        chk({7'h00, PAGE_CLEARING}, 8'h01);
        n = 0;
        while (PAGE_CLEARING !== 1'b0) tick(n);
        rc(OFS_DATA, FILL);
        wr(OFS_BLK, 8'h01, RESP_OKAY);
        rc(OFS_BLK, 8'h01);
        stop_test();
    end
endmodule : osd_display_acq_control_regs_tb_top
